//--- prfc_consts.svh
`ifndef PRFC_CONSTS_SVH
`define PRFC_CONSTS_SVH

// register indices (byte bus, printed offsets kept as they are)
`define PRFC_ADDR_FREQ_CTRL 8'h21
`define PRFC_ADDR_ENABLE 8'h20
`define PRFC_ADDR_IRQ_STATUS 8'h30
`define PRFC_ADDR_IRQ_MASK 8'h31
`define PRFC_ADDR_ACTIVE 8'h32

// field positions in the frequency control register
`define PRFC_INTERVAL_MSB 7
`define PRFC_INTERVAL_LSB 4
`define PRFC_HALF_BIT 3
`define PRFC_PRESCALE_MSB 2
`define PRFC_PRESCALE_LSB 1
`define PRFC_FLAG_BIT 0

// field positions in the enable register
`define PRFC_LOAD_OKAY_BIT 1
`define PRFC_RIE_BIT 0

// reset values
`define PRFC_INTERVAL_RST 4'h0
`define PRFC_PRESCALE_RST 2'h0
`define PRFC_MASK_RST 1'h0

`endif

//--- prfc_interval_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "prfc_consts.svh"

module prfc_interval_counter (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // opportunities and interval
  input wire logic opportunity,
  input wire logic [3:0] interval,
  // reload decision
  output logic reload
);

  logic [3:0] count_q;
  logic [3:0] count_d;
  logic hit;

  // reload on opportunity number interval+1
  assign hit = opportunity && (count_q >= interval);
  assign reload = hit;
  assign count_d = hit ? 4'h0 : (opportunity ? count_q + 4'h1 : count_q);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= 4'h0;
    end else if (clk_en) begin
      count_q <= count_d;
    end
  end

endmodule // prfc_interval_counter
`default_nettype wire

//--- prfc_pkg.sv
package prfc_pkg;

  typedef enum logic [1:0] {
    PRFC_CLR_IDLE = 2'b00,
    PRFC_CLR_ARMED = 2'b01
  } prfc_clr_state_t;

endpackage

//--- prfc_reload_ctrl.sv
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "prfc_consts.svh"


module prfc_reload_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  // pwm counter events
  input wire logic cycle_start,
  input wire logic half_cycle,
  input wire logic center_aligned,
  // active settings
  output logic [3:0] interval_active,
  output logic [1:0] prescale_active,
  output logic half_active,
  output logic reload_pulse,
  output logic load_okay,
  // interrupts
  output logic reload_irq,
  output logic irq
);

  logic [3:0] interval_buf_q;
  logic [1:0] prescale_buf_q;
  logic half_q;
  logic [3:0] interval_act_q;
  logic [1:0] prescale_act_q;
  logic flag_q;
  logic load_okay_q;
  logic rie_q;
  logic reload_pulse_q;
  logic reload_irq_q;
  logic irq_q;
  logic sts_q;
  logic mask_q;
  logic [7:0] rdata_q;
  prfc_pkg::prfc_clr_state_t clr_q;
  prfc_pkg::prfc_clr_state_t clr_d;

  // decode
  logic sel_fq;
  logic sel_en;
  logic sel_sts;
  logic sel_msk;
  logic sel_act;
  logic wr_fq;
  logic rd_fq;
  logic opportunity;
  logic reload;
  logic flag_set;
  logic flag_clr;
  logic [7:0] fq_read;
  logic [7:0] rd_mux;

  assign sel_fq = addr == `PRFC_ADDR_FREQ_CTRL;
  assign sel_en = addr == `PRFC_ADDR_ENABLE;
  assign sel_sts = addr == `PRFC_ADDR_IRQ_STATUS;
  assign sel_msk = addr == `PRFC_ADDR_IRQ_MASK;
  assign sel_act = addr == `PRFC_ADDR_ACTIVE;
  assign wr_fq = wr_en && sel_fq;
  assign rd_fq = rd_en && sel_fq;

  // half-cycle points only count in center-aligned mode
  assign opportunity = cycle_start ||
    (half_q && center_aligned && half_cycle);

  prfc_interval_counter u_cnt (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .opportunity(opportunity),
    .interval(interval_act_q),
    .reload(reload)
  );

  assign flag_set = reload;
  // clear only from the armed state and never against a reload
  assign flag_clr = wr_fq && wdata[`PRFC_FLAG_BIT] &&
    (clr_q == prfc_pkg::PRFC_CLR_ARMED) && !flag_set;

  always_comb begin
    clr_d = clr_q;
    unique case (clr_q)
      prfc_pkg::PRFC_CLR_IDLE: begin
        if (rd_fq && flag_q && !flag_set) clr_d = prfc_pkg::PRFC_CLR_ARMED;
      end
      prfc_pkg::PRFC_CLR_ARMED: begin
        if (flag_set || wr_fq) clr_d = prfc_pkg::PRFC_CLR_IDLE;
      end
      default: clr_d = prfc_pkg::PRFC_CLR_IDLE;
    endcase
  end

  // buffered values are what software reads back
  assign fq_read = {interval_buf_q, half_q, prescale_buf_q, flag_q};
  assign rd_mux = sel_fq ? fq_read :
    sel_en ? {6'h00, load_okay_q, rie_q} :
    sel_sts ? {7'h00, sts_q} :
    sel_msk ? {7'h00, mask_q} :
    sel_act ? {interval_act_q, half_q, prescale_act_q, 1'b0} : 8'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clr_q <= prfc_pkg::PRFC_CLR_IDLE;
      interval_buf_q <= `PRFC_INTERVAL_RST;
      prescale_buf_q <= `PRFC_PRESCALE_RST;
      half_q <= 1'b0;
      rdata_q <= 8'h00;
    end else if (clk_en) begin
      clr_q <= clr_d;
      rdata_q <= rd_en ? rd_mux : 8'h00;
      if (wr_fq) begin
        interval_buf_q <= wdata[`PRFC_INTERVAL_MSB:`PRFC_INTERVAL_LSB];
        half_q <= wdata[`PRFC_HALF_BIT];
        prescale_buf_q <= wdata[`PRFC_PRESCALE_MSB:`PRFC_PRESCALE_LSB];
      end
    end
  end

  // active copies
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      interval_act_q <= `PRFC_INTERVAL_RST;
      prescale_act_q <= `PRFC_PRESCALE_RST;
    end else if (clk_en) begin
      if (reload) interval_act_q <= interval_buf_q;
      if (cycle_start && load_okay_q) prescale_act_q <= prescale_buf_q;
    end
  end

  // flag, load-okay, enable; flag set beats clear, load-okay clear on reload beats a write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
      load_okay_q <= 1'b0;
      rie_q <= 1'b0;
    end else if (clk_en) begin
      if (flag_set) flag_q <= 1'b1;
      else if (flag_clr) flag_q <= 1'b0;
      if (reload && load_okay_q) load_okay_q <= 1'b0;
      else if (wr_en && sel_en) load_okay_q <= wdata[`PRFC_LOAD_OKAY_BIT];
      if (wr_en && sel_en) rie_q <= wdata[`PRFC_RIE_BIT];
    end
  end

  // status bit cleared by reading it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sts_q <= 1'b0;
      mask_q <= `PRFC_MASK_RST;
      reload_pulse_q <= 1'b0;
      reload_irq_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (clk_en) begin
      if (reload) sts_q <= 1'b1;
      else if (rd_en && sel_sts) sts_q <= 1'b0;
      if (wr_en && sel_msk) mask_q <= wdata[0];
      reload_pulse_q <= reload;
      reload_irq_q <= (flag_q || flag_set) && !flag_clr && rie_q;
      irq_q <= (sts_q || reload) && mask_q;
    end
  end

  assign rdata = rdata_q;
  assign interval_active = interval_act_q;
  assign prescale_active = prescale_act_q;
  assign half_active = half_q;
  assign reload_pulse = reload_pulse_q;
  assign load_okay = load_okay_q;
  assign reload_irq = reload_irq_q;
  assign irq = irq_q;

  // checks
  property p_flag_set;
    @(posedge clk) disable iff (!rst_n)
      clk_en && reload |=> flag_q;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");

  property p_no_clear_unarmed;
    @(posedge clk) disable iff (!rst_n)
      clk_en && flag_q && clr_q == prfc_pkg::PRFC_CLR_IDLE |=> flag_q;
  endproperty
  a_no_clear_unarmed: assert property (p_no_clear_unarmed)
    else $error("bad clear");

  property p_reload_beats;
    @(posedge clk) disable iff (!rst_n)
      clk_en && reload && wr_fq && wdata[0] |=> flag_q;
  endproperty
  a_reload_beats: assert property (p_reload_beats)
    else $error("clear won");

  // request follows the flag, one cycle behind a change of the enable
  property p_irq;
    @(posedge clk) disable iff (!rst_n)
      clk_en |=> reload_irq == (flag_q && $past(rie_q));
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_irq_drop;
    @(posedge clk) disable iff (!rst_n)
      clk_en && flag_clr |=> !reload_irq;
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("irq stuck");

  property p_interval_load;
    @(posedge clk) disable iff (!rst_n)
      clk_en && reload |=> interval_act_q == $past(interval_buf_q);
  endproperty
  a_interval_load: assert property (p_interval_load)
    else $error("interval");

  property p_prescale_hold;
    @(posedge clk) disable iff (!rst_n)
      clk_en && !load_okay_q |=> $stable(prescale_act_q);
  endproperty
  a_prescale_hold: assert property (p_prescale_hold)
    else $error("prescale");

  property p_ldok_clear;
    @(posedge clk) disable iff (!rst_n)
      clk_en && reload && load_okay_q |=> !load_okay_q;
  endproperty
  a_ldok_clear: assert property (p_ldok_clear) else $error("ldok");

  property p_readback;
    @(posedge clk) disable iff (!rst_n)
      clk_en && rd_fq |=> rdata[7:4] == $past(interval_buf_q);
  endproperty
  a_readback: assert property (p_readback) else $error("readback");

  property p_every_opportunity;
    @(posedge clk) disable iff (!rst_n)
      opportunity && interval_act_q == 4'h0 |-> reload;
  endproperty
  a_every_opportunity: assert property (p_every_opportunity)
    else $error("no reload");

  property p_half_gate;
    @(posedge clk) disable iff (!rst_n)
      !cycle_start && !(half_q && center_aligned) |-> !reload;
  endproperty
  a_half_gate: assert property (p_half_gate)
    else $error("stray reload");

  property p_interval_hold;
    @(posedge clk) disable iff (!rst_n)
      clk_en && !reload |=> $stable(interval_act_q);
  endproperty
  a_interval_hold: assert property (p_interval_hold)
    else $error("interval early");

  property p_prescale_load;
    @(posedge clk) disable iff (!rst_n)
      clk_en && cycle_start && load_okay_q |=>
        prescale_act_q == $past(prescale_buf_q);
  endproperty
  a_prescale_load: assert property (p_prescale_load)
    else $error("prescale not loaded");

  property p_prescale_readback;
    @(posedge clk) disable iff (!rst_n)
      clk_en && rd_fq |=> rdata[2:1] == $past(prescale_buf_q);
  endproperty
  a_prescale_readback: assert property (p_prescale_readback)
    else $error("prescale readback");

  property p_flag_cleared;
    @(posedge clk) disable iff (!rst_n)
      clk_en && flag_clr |=> !flag_q;
  endproperty
  a_flag_cleared: assert property (p_flag_cleared)
    else $error("flag kept");

  c_reload: cover property (@(posedge clk) disable iff (!rst_n) reload);
  c_clear: cover property (@(posedge clk) disable iff (!rst_n) flag_clr);
  c_cancel: cover property (@(posedge clk) disable iff (!rst_n)
    clr_q == prfc_pkg::PRFC_CLR_ARMED && reload);
  c_half: cover property (@(posedge clk) disable iff (!rst_n)
    reload && !cycle_start);
  c_prescale: cover property (@(posedge clk) disable iff (!rst_n)
    clk_en && cycle_start && load_okay_q);

endmodule // prfc_reload_ctrl
`default_nettype wire

//--- pwm_reload_frequency_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "prfc_consts.svh"

module pwm_reload_frequency_ctrl_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic cycle_start = 1'b0;
  logic half_cycle = 1'b0;
  logic center_aligned = 1'b0;
  logic [7:0] rdata;
  logic [3:0] interval_active;
  logic [1:0] prescale_active;
  logic half_active, reload_pulse, load_okay, reload_irq, irq;
  int failures = 0;
  int compares = 0;
  int cyc = 0;
  int cnt;
  logic rd_q = 1'b0;
  logic rl;
  logic [3:0] n;
  logic [3:0] pn = 4'h0;
  logic [1:0] p;
  logic [7:0] q[$];

  prfc_reload_ctrl dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .cycle_start(cycle_start), .half_cycle(half_cycle),
    .center_aligned(center_aligned), .interval_active(interval_active),
    .prescale_active(prescale_active), .half_active(half_active),
    .reload_pulse(reload_pulse), .load_okay(load_okay),
    .reload_irq(reload_irq), .irq(irq));

  always #12.5 clk = ~clk;

  task automatic tally_and_finish();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge clk) rd_q <= rd_en;
  always @(negedge clk) begin
    if (rd_q === 1'b1) begin
      check(rdata, q.pop_front());
    end
  end

  // hang guard, well above the few hundred cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    q.push_back(e);
    @(posedge clk);
    rd_en <= 1'b0;
  endtask

  // one opportunity; rl holds the reload pulse it caused
  task automatic op(input logic cs, input logic hc);
    @(posedge clk);
    cycle_start <= cs;
    half_cycle <= hc;
    @(posedge clk);
    cycle_start <= 1'b0;
    half_cycle <= 1'b0;
    #1 rl = reload_pulse;
  endtask

  task automatic count_ops(output int c);
    c = 0;
    do begin
      op(1'b1, 1'b0);
      c++;
    end while (rl !== 1'b1 && c < 20);
  endtask

  task automatic clr(input logic [7:0] v);
    rd(`PRFC_ADDR_FREQ_CTRL, v | 8'h01);
    wr(`PRFC_ADDR_FREQ_CTRL, v | 8'h01);
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  initial begin
    void'($urandom(32'h4d79));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(`PRFC_ADDR_FREQ_CTRL, 8'h00);
    rd(`PRFC_ADDR_ENABLE, 8'h00);
    rd(`PRFC_ADDR_IRQ_MASK, 8'h00);
    wr(8'h55, 8'hff);
    rd(8'h55, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      n = (i == 0) ? 4'hf : (i == 1) ? 4'h0 : 4'($urandom_range(1, 14));
      p = 2'($urandom);
      wr(`PRFC_ADDR_FREQ_CTRL, {n, 1'b0, p, 1'b0});
      rd(`PRFC_ADDR_FREQ_CTRL, {n, 1'b0, p, 1'b0});
      rd(`PRFC_ADDR_ACTIVE, {pn, 4'h0});
      count_ops(cnt);
      rd(`PRFC_ADDR_ACTIVE, {n, 4'h0});
      check(8'(interval_active), {4'h0, n});
      count_ops(cnt);
      check(8'(cnt), {4'h0, n} + 8'h01);
      rd(`PRFC_ADDR_FREQ_CTRL, {n, 1'b0, p, 1'b1});
      clr({n, 1'b0, p, 1'b0});
      rd(`PRFC_ADDR_FREQ_CTRL, {n, 1'b0, p, 1'b0});
      pn = n;
    end
    $display("test interval done");
    wr(`PRFC_ADDR_FREQ_CTRL, 8'h04);
    count_ops(cnt);
    rd(`PRFC_ADDR_ACTIVE, 8'h00);
    wr(`PRFC_ADDR_ENABLE, 8'h02);
    rd(`PRFC_ADDR_ENABLE, 8'h02);
    check(8'(load_okay), 8'h01);
    op(1'b1, 1'b0);
    rd(`PRFC_ADDR_ACTIVE, 8'h04);
    check(8'(prescale_active), 8'h02);
    check(8'(load_okay), 8'h00);
    rd(`PRFC_ADDR_ENABLE, 8'h00);
    $display("test prescale done");
    wr(`PRFC_ADDR_ENABLE, 8'h01);
    wr(`PRFC_ADDR_FREQ_CTRL, 8'h05);
    settle();
    check(reload_irq, 8'h01);
    rd(`PRFC_ADDR_FREQ_CTRL, 8'h05);
    op(1'b1, 1'b0);
    wr(`PRFC_ADDR_FREQ_CTRL, 8'h05);
    clr(8'h04);
    settle();
    check(reload_irq, 8'h00);
    rd(`PRFC_ADDR_FREQ_CTRL, 8'h04);
    $display("test flag done");
    for (int i = 0; i < 3; i++) begin
      wr(`PRFC_ADDR_FREQ_CTRL, {4'h0, i < 2, 2'b10, 1'b0});
      center_aligned <= (i != 1);
      op(1'b0, 1'b1);
      check(rl, i == 0);
      check(8'(half_active), 8'(i < 2));
      if (i == 0) begin
        clr(8'h0c);
      end
    end
    $display("test half done");
    wr(`PRFC_ADDR_IRQ_MASK, 8'h01);
    settle();
    check(irq, 8'h01);
    rd(`PRFC_ADDR_IRQ_STATUS, 8'h01);
    settle();
    check(irq, 8'h00);
    @(posedge clk);
    clk_en <= 1'b0;
    op(1'b1, 1'b0);
    check(rl, 8'h00);
    @(posedge clk);
    clk_en <= 1'b1;
    wr(`PRFC_ADDR_IRQ_MASK, 8'h00);
    op(1'b1, 1'b0);
    check(rl, 8'h01);
    settle();
    check(irq, 8'h00);
    rd(`PRFC_ADDR_IRQ_STATUS, 8'h01);
    $display("test status done");
    repeat (4) @(posedge clk);
    tally_and_finish();
  end
endmodule // pwm_reload_frequency_ctrl_test

`default_nettype wire
